// [design/btdc_pkg.sv]
// btdc_pkg: register map, bit positions and sizes for the debug trace control
// assumes a 32-bit apb slave; the 64-bit register is split in two words
package btdc_pkg;
    // ========================================================
    // register map
    localparam int unsigned ADDR_W          = 12;
    localparam logic [11:0] CTRL_INDEX      = 12'h1d9;
    localparam logic [11:0] CTRL_LO_ADDR    = 12'h764;  // index * 4
    localparam logic [11:0] CTRL_HI_ADDR    = 12'h768;
    localparam logic [11:0] STATUS_ADDR     = 12'h76c;
    localparam logic [11:0] CNT_EN_ADDR     = 12'h770;
    localparam logic [11:0] LOG_DEPTH_ADDR  = 12'h774;
    // ========================================================
    // control bit positions
    localparam int unsigned BIT_BRANCH_LOG  = 0;
    localparam int unsigned BIT_STEP_JUMPS  = 1;
    localparam int unsigned BIT_BUS_MSG     = 6;
    localparam int unsigned BIT_MEM_LOG     = 7;
    localparam int unsigned BIT_FULL_IRQ    = 8;
    localparam int unsigned BIT_SKIP_KERN   = 9;
    localparam int unsigned BIT_SKIP_USER   = 10;
    localparam int unsigned BIT_HOLD_LOG    = 11;
    localparam int unsigned BIT_HOLD_CNT    = 12;
    localparam int unsigned BIT_PAUSE_MGMT  = 14;
    localparam logic [31:0] CTRL_MASK       = 32'h00005fc3;
    localparam logic [31:0] CTRL_RESET      = 32'h00000000;
    localparam logic [31:0] MGMT_CLR_MASK   = 32'h000000c3;
    // ========================================================
    // sizes and codes
    localparam int unsigned CNT_W           = 8;
    localparam logic [7:0]  CNT_ALL_ON      = 8'hff;
    localparam logic [7:0]  CNT_ALL_OFF     = 8'h00;
    localparam int unsigned STACK_N         = 4;
    localparam int unsigned PTR_W           = 2;
    localparam int unsigned BUF_W           = 8;
    localparam logic [7:0]  BUF_DEPTH_RST   = 8'h10;
    localparam logic [7:0]  BREAK_VECTOR    = 8'h03;
    localparam logic [7:0]  DEBUG_VECTOR    = 8'h01;
    localparam logic [1:0]  PRIV_KERNEL     = 2'h0;
    localparam logic        MULTI_ENABLE_OK = 1'b1;
    typedef enum logic [1:0] {
        BTDC_ST_RUN,
        BTDC_ST_MGMT
    } btdc_state_t;
endpackage

// [design/btdc_core.sv]
// btdc_core: debug trace control register with its branch logging effects
// assumes core events arrive as one-cycle pulses on pclk from core logic
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
module btdc_core
    import btdc_pkg::*;
(
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [btdc_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic                   ev_branch,
    input  wire logic                   ev_irq,
    input  wire logic                   ev_exc,
    input  wire logic                   ev_insn_done,
    input  wire logic                   ev_trap_insn,
    input  wire logic [31:0]            ev_from,
    input  wire logic [31:0]            ev_to,
    input  wire logic [1:0]             priv_level,
    input  wire logic                   step_flag,
    input  wire logic                   counter_irq,
    input  wire logic                   mgmt_irq,
    input  wire logic                   mgmt_return,
    output logic                        fault_valid,
    output logic      [7:0]             fault_vector,
    output logic                        branch_msg_valid,
    output logic      [63:0]            branch_msg,
    output logic                        mem_wr_valid,
    output logic      [7:0]             mem_wr_index,
    output logic      [63:0]            mem_wr_data,
    output logic                        log_full_irq,
    output logic      [7:0]             counter_enables,
    output logic      [63:0]            top_record,
    output logic      [1:0]             top_ptr
);
    import btdc_pkg::*;

    // ========================================================
    // apb decode
    logic        wr_en;
    logic        rd_en;
    logic        hit;
    logic [31:0] ctrl_reg;
    logic [31:0] ctrl_save_reg;
    logic [7:0]  cnt_reg;
    logic [7:0]  depth_reg;
    logic [7:0]  wptr_reg;
    logic        full_reg;
    logic        frozen_reg;
    btdc_state_t state_reg;
    logic [63:0] stack_reg [STACK_N];
    logic [PTR_W-1:0] tos_reg;

    function automatic logic is_reg(input logic [ADDR_W-1:0] a);
        return a == CTRL_LO_ADDR || a == CTRL_HI_ADDR || a == STATUS_ADDR ||
               a == CNT_EN_ADDR || a == LOG_DEPTH_ADDR;
    endfunction

    assign wr_en = psel && penable && pwrite && pready;
    assign rd_en = psel && !penable && !pwrite;
    assign hit   = is_reg(paddr);

    // no wait state: pready rises in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !hit;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (rd_en) begin
            unique case (paddr)
                CTRL_LO_ADDR:   prdata <= ctrl_reg & CTRL_MASK;
                STATUS_ADDR:    prdata <= {27'h0000000, frozen_reg,
                                           state_reg == BTDC_ST_MGMT,
                                           full_reg, tos_reg};
                CNT_EN_ADDR:    prdata <= {24'h000000, cnt_reg};
                LOG_DEPTH_ADDR: prdata <= {24'h000000, depth_reg};
                default:        prdata <= 32'h00000000;
            endcase
        end
    end

    // ========================================================
    // event qualification
    logic any_ev;
    logic priv_ok;
    logic trace_ok;
    logic log_stack;
    logic db_fault;
    logic step_hit;

    // events are taken branches, irqs and non-debug exceptions only
    assign any_ev  = ev_branch || ev_irq || ev_exc;
    assign priv_ok = !((ctrl_reg[BIT_SKIP_KERN] && priv_level == PRIV_KERNEL)
                  || (ctrl_reg[BIT_SKIP_USER] && priv_level != PRIV_KERNEL));
    assign trace_ok = any_ev && priv_ok;
    // bus messages also keep the stack running, though they are built from the event addresses
    assign log_stack = any_ev && !frozen_reg &&
                       (ctrl_reg[BIT_BRANCH_LOG] ||
                        ctrl_reg[BIT_BUS_MSG]);
    assign step_hit = step_flag && ev_insn_done &&
                      (!ctrl_reg[BIT_STEP_JUMPS] || ev_branch);
    assign db_fault = step_hit;

    // ========================================================
    // control register and management mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg      <= CTRL_RESET;
            ctrl_save_reg <= CTRL_RESET;
            state_reg     <= BTDC_ST_RUN;
        end else begin
            if (wr_en && paddr == CTRL_LO_ADDR)
                ctrl_reg <= pwdata & CTRL_MASK;
            unique case (state_reg)
                BTDC_ST_RUN: begin
                    if (mgmt_irq) begin
                        state_reg <= BTDC_ST_MGMT;
                        if (ctrl_reg[BIT_PAUSE_MGMT]) begin
                            ctrl_save_reg <= ctrl_reg;
                            ctrl_reg <= ctrl_reg & ~MGMT_CLR_MASK;
                        end
                    end
                end
                BTDC_ST_MGMT: begin
                    if (mgmt_return) begin
                        state_reg <= BTDC_ST_RUN;
                        if (ctrl_save_reg[BIT_PAUSE_MGMT])
                            ctrl_reg <= ctrl_save_reg;
                    end
                end
            endcase
            // hardware clears last, so they beat writes and restores
            if (db_fault) begin
                ctrl_reg[BIT_BRANCH_LOG] <= 1'b0;
                ctrl_reg[BIT_STEP_JUMPS] <= 1'b0;
            end
            if (counter_irq && ctrl_reg[BIT_HOLD_LOG])
                ctrl_reg[BIT_BRANCH_LOG] <= 1'b0;
        end
    end

    // ========================================================
    // counter enables
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= CNT_ALL_OFF;
        end else if (state_reg == BTDC_ST_RUN && mgmt_irq &&
                     ctrl_reg[BIT_PAUSE_MGMT]) begin
            cnt_reg <= CNT_ALL_OFF;
        end else if (state_reg == BTDC_ST_MGMT && mgmt_return &&
                     ctrl_save_reg[BIT_PAUSE_MGMT]) begin
            cnt_reg <= CNT_ALL_ON;
        end else if (counter_irq && ctrl_reg[BIT_HOLD_CNT]) begin
            cnt_reg <= CNT_ALL_OFF;
        end else if (wr_en && paddr == CNT_EN_ADDR) begin
            cnt_reg <= pwdata[CNT_W-1:0];
        end
    end

    // ========================================================
    // branch record stack
    // frozen until software rewrites the control word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            frozen_reg <= 1'b0;
        else if (counter_irq && ctrl_reg[BIT_HOLD_LOG])
            frozen_reg <= 1'b1;
        else if (wr_en && paddr == CTRL_LO_ADDR)
            frozen_reg <= 1'b0;
    end

    // entries persist across a debug fault; only the branch log and step-on-jumps enables drop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tos_reg <= '0;
            for (int i = 0; i < STACK_N; i++)
                stack_reg[i] <= 64'h0;
        end else if (log_stack) begin
            tos_reg <= tos_reg + 2'h1;
            stack_reg[tos_reg + 2'h1] <= {ev_from, ev_to};
        end
    end

    // ========================================================
    // bus messages and memory store
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            branch_msg_valid <= 1'b0;
            branch_msg       <= 64'h0;
        end else begin
            branch_msg_valid <= trace_ok && ctrl_reg[BIT_BUS_MSG] &&
                                (MULTI_ENABLE_OK ||
                                 !ctrl_reg[BIT_BRANCH_LOG]);
            if (trace_ok)
                branch_msg <= {ev_from, ev_to};
        end
    end

    logic mem_go;
    assign mem_go = trace_ok && ctrl_reg[BIT_MEM_LOG] && !full_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wptr_reg     <= 8'h00;
            full_reg     <= 1'b0;
            log_full_irq <= 1'b0;
            mem_wr_valid <= 1'b0;
            mem_wr_index <= 8'h00;
            mem_wr_data  <= 64'h0;
            depth_reg    <= BUF_DEPTH_RST;
        end else begin
            mem_wr_valid <= mem_go;
            log_full_irq <= 1'b0;
            if (wr_en && paddr == LOG_DEPTH_ADDR)
                depth_reg <= pwdata[BUF_W-1:0];
            // a store beside a depth write wins: wptr_reg advances and is not reset
            if (mem_go) begin
                mem_wr_index <= wptr_reg;
                mem_wr_data  <= {ev_from, ev_to};
                if (wptr_reg + 8'h01 >= depth_reg) begin
                    wptr_reg <= 8'h00;
                    if (ctrl_reg[BIT_FULL_IRQ]) begin
                        full_reg     <= 1'b1;
                        log_full_irq <= 1'b1;
                    end
                end else begin
                    wptr_reg <= wptr_reg + 8'h01;
                end
            end else if (wr_en && paddr == LOG_DEPTH_ADDR) begin
                wptr_reg <= 8'h00;
                full_reg <= 1'b0;
            end
        end
    end

    // ========================================================
    // faults and observation outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_valid     <= 1'b0;
            fault_vector    <= 8'h00;
            counter_enables <= CNT_ALL_OFF;
            top_record      <= 64'h0;
            top_ptr         <= '0;
        end else begin
            fault_valid     <= ev_trap_insn || db_fault;
            if (ev_trap_insn)
                fault_vector <= BREAK_VECTOR;
            else if (db_fault)
                fault_vector <= DEBUG_VECTOR;
            counter_enables <= cnt_reg;
            top_record      <= stack_reg[tos_reg];
            top_ptr         <= tos_reg;
        end
    end

    // ========================================================
    // checks
    trap_vector_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        ev_trap_insn |=> fault_valid && fault_vector == BREAK_VECTOR)
        else $error("trap did not raise vector 3");
    step_clear_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        db_fault |=> !ctrl_reg[BIT_STEP_JUMPS] && !ctrl_reg[BIT_BRANCH_LOG])
        else $error("debug fault left enables set");
    step_branch_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (step_flag && ev_insn_done && ctrl_reg[BIT_STEP_JUMPS] && !ev_branch
         && !ev_trap_insn) |=> !fault_valid)
        else $error("step fault without branch");
    skip_kern_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ctrl_reg[BIT_SKIP_KERN] && priv_level == PRIV_KERNEL)
        |=> !branch_msg_valid)
        else $error("message at level zero");
    skip_user_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ctrl_reg[BIT_SKIP_USER] && priv_level != PRIV_KERNEL)
        |=> !branch_msg_valid)
        else $error("message above level zero");
    bus_msg_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ev_branch && ctrl_reg[BIT_BUS_MSG] && priv_ok) |=> branch_msg_valid)
        else $error("branch message missing");
    stack_hold_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (frozen_reg && !wr_en) |=> $stable(tos_reg))
        else $error("frozen stack moved");
    cnt_freeze_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (counter_irq && ctrl_reg[BIT_HOLD_CNT] && !mgmt_irq && !mgmt_return)
        |=> cnt_reg == CNT_ALL_OFF ##1 counter_enables == CNT_ALL_OFF)
        else $error("counters not frozen");
    mgmt_restore_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (state_reg == BTDC_ST_MGMT && mgmt_return
         && ctrl_save_reg[BIT_PAUSE_MGMT] && !db_fault && !counter_irq)
        |=> ctrl_reg == $past(ctrl_save_reg) && cnt_reg == CNT_ALL_ON)
        else $error("mgmt return did not restore");
    mgmt_entry_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (state_reg == BTDC_ST_RUN && mgmt_irq && ctrl_reg[BIT_PAUSE_MGMT])
        |=> (ctrl_reg & MGMT_CLR_MASK) == 32'h0 && cnt_reg == CNT_ALL_OFF)
        else $error("mgmt entry did not clear");
    branch_log_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        log_stack |=> tos_reg == $past(tos_reg) + 2'h1
            && stack_reg[tos_reg] == {$past(ev_from), $past(ev_to)})
        else $error("branch record not pushed");
    no_fault_log_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (db_fault && !any_ev) |=> $stable(tos_reg))
        else $error("debug fault was logged");
    fault_keep_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (db_fault && ctrl_reg[BIT_BUS_MSG] && !wr_en && !mgmt_irq
         && !mgmt_return) |=> ctrl_reg[BIT_BUS_MSG])
        else $error("debug fault cleared message enable");
    hold_log_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (counter_irq && ctrl_reg[BIT_HOLD_LOG])
        |=> frozen_reg && !ctrl_reg[BIT_BRANCH_LOG])
        else $error("counter irq did not freeze stack");
    both_on_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (trace_ok && !frozen_reg && ctrl_reg[BIT_BUS_MSG]
         && ctrl_reg[BIT_BRANCH_LOG]) |=> branch_msg_valid
            && tos_reg == $past(tos_reg) + 2'h1)
        else $error("log and message not together");
    mem_log_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        mem_go |=> mem_wr_valid
            && mem_wr_data == {$past(ev_from), $past(ev_to)})
        else $error("memory store missing");
    full_stop_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        full_reg |=> !mem_wr_valid)
        else $error("store into full buffer");
    wrap_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (mem_go && !ctrl_reg[BIT_FULL_IRQ]) |=> !log_full_irq && !full_reg)
        else $error("circular buffer raised full");
    reserved_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ctrl_reg & ~CTRL_MASK) == 32'h0)
        else $error("unassigned control bit set");
    ctrl_read_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (rd_en && paddr == CTRL_LO_ADDR) |=> prdata == $past(ctrl_reg))
        else $error("control read wrong");
endmodule

// [dv/btdc_bus_watch.sv]
// btdc_bus_watch: passive debug device that watches branch messages
// assumes messages and memory log writes are one-cycle pulses on pclk
`timescale 1ns/1ps
module btdc_bus_watch (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        branch_msg_valid,
    input  wire logic [63:0] branch_msg,
    input  wire logic        mem_wr_valid,
    output logic      [7:0]  msg_cnt,
    output logic      [63:0] last_msg,
    output logic      [7:0]  mem_cnt
);
    // ========================================================
    // capture
    // counts and keeps the last message, so a stray extra pulse shows up as a count error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            msg_cnt  <= 8'h00;
            last_msg <= 64'h0;
        end else if (branch_msg_valid) begin
            msg_cnt  <= msg_cnt + 8'h01;
            last_msg <= branch_msg;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_cnt <= 8'h00;
        end else if (mem_wr_valid) begin
            mem_cnt <= mem_cnt + 8'h01;
        end
    end
endmodule

// [dv/branch_trace_debug_control_tb_top.sv]
// branch_trace_debug_control_tb_top: apb and core-event driven bench
// assumes the register map and answer timing of btdc_pkg and btdc_core
`timescale 1ns/1ps
module branch_trace_debug_control_tb_top;
    import btdc_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, step_flag;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, src, dst;
    logic        pready, pslverr, fault_valid, branch_msg_valid;
    logic        mem_wr_valid, log_full_irq;
    logic [7:0]  fault_vector, mem_wr_index, counter_enables, evs;
    logic [7:0]  msg_cnt, mem_cnt;
    logic [63:0] branch_msg, mem_wr_data, top_record, last_msg, rec;
    logic [1:0]  top_ptr, priv_level, p0;
    int          n_fail, num_checks;
    btdc_core btdc_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ev_branch(evs[0]), .ev_irq(evs[1]), .ev_exc(evs[2]),
        .ev_insn_done(evs[3]), .ev_trap_insn(evs[4]), .ev_from(src),
        .ev_to(dst), .priv_level(priv_level), .step_flag(step_flag),
        .counter_irq(evs[5]), .mgmt_irq(evs[6]), .mgmt_return(evs[7]),
        .fault_valid(fault_valid), .fault_vector(fault_vector),
        .branch_msg_valid(branch_msg_valid), .branch_msg(branch_msg),
        .mem_wr_valid(mem_wr_valid), .mem_wr_index(mem_wr_index),
        .mem_wr_data(mem_wr_data), .log_full_irq(log_full_irq),
        .counter_enables(counter_enables), .top_record(top_record),
        .top_ptr(top_ptr));
    btdc_bus_watch btdc_bus_watch_inst (.pclk(pclk), .presetn(presetn),
        .branch_msg_valid(branch_msg_valid), .branch_msg(branch_msg),
        .mem_wr_valid(mem_wr_valid), .msg_cnt(msg_cnt),
        .last_msg(last_msg), .mem_cnt(mem_cnt));
    always #20 pclk = ~pclk;
    // ========================================================
    // tasks
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [63:0] e,
                       input logic [63:0] g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    // bounded wait: a slave that never answers ends the run
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 16) begin
            n_fail++;
            $display("MISMATCH pready expected 1 seen 0");
            finish_test();
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x,
                      input string nm);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(nm, {32'h0, x}, {32'h0, r});
    endtask
    // one-cycle event pulse; outputs are looked at in their answer cycle
    task automatic ev(input logic [7:0] k);
        @(posedge pclk);
        evs <= k;
        @(posedge pclk);
        evs <= 8'h00;
        #1;
    endtask
    task automatic tick();
        @(posedge pclk);
        #1;
    endtask
    // ========================================================
    // sequence
    initial begin
        logic [31:0] r;
        logic        e;
        pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0;
        pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0; evs = 8'h00;
        step_flag = 1'b0; priv_level = 2'h0;
        src = 32'h0000_1234; dst = 32'h0000_5678;
        rec = {src, dst};
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd(CTRL_LO_ADDR, 32'h0, "ctrl_lo");
        rd(CTRL_HI_ADDR, 32'h0, "ctrl_hi");
        rd(LOG_DEPTH_ADDR, 32'h10, "depth");
        apb(1'b0, 12'hffc, 32'h0, r, e);
        chk("unmapped_err", 64'h1, {63'h0, e});
        wr(CTRL_LO_ADDR, 32'hffff_ffff);
        rd(CTRL_LO_ADDR, 32'h0000_5fc3, "ctrl_mask");
        wr(CTRL_LO_ADDR, 32'h0);
        ev(8'h10);
        chk("brk_valid", 64'h1, {63'h0, fault_valid});
        chk("brk_vector", 64'h3, {56'h0, fault_vector});
        $display("test registers and breakpoint done");
        wr(CTRL_LO_ADDR, 32'h40);
        ev(8'h01);
        chk("msg_valid", 64'h1, {63'h0, branch_msg_valid});
        chk("msg_data", rec, branch_msg);
        tick();
        chk("stack_by_msg", rec, top_record);
        ev(8'h02);
        ev(8'h04);
        wr(CTRL_LO_ADDR, 32'h240);
        ev(8'h01);
        chk("skip_kern", 64'h0, {63'h0, branch_msg_valid});
        @(posedge pclk);
        priv_level <= 2'h1;
        ev(8'h01);
        chk("kern_user", 64'h1, {63'h0, branch_msg_valid});
        wr(CTRL_LO_ADDR, 32'h440);
        ev(8'h01);
        chk("skip_user", 64'h0, {63'h0, branch_msg_valid});
        @(posedge pclk);
        priv_level <= 2'h0;
        ev(8'h01);
        chk("user_kern", 64'h1, {63'h0, branch_msg_valid});
        tick();
        chk("msg_count", 64'h5, {56'h0, msg_cnt});
        chk("last_msg", rec, last_msg);
        $display("test bus messages done");
        wr(LOG_DEPTH_ADDR, 32'h2);
        wr(CTRL_LO_ADDR, 32'h180);
        ev(8'h01);
        chk("mem_valid", 64'h1, {63'h0, mem_wr_valid});
        chk("mem_data", rec, mem_wr_data);
        ev(8'h01);
        chk("full_irq", 64'h1, {63'h0, log_full_irq});
        ev(8'h01);
        chk("full_stop", 64'h0, {63'h0, mem_wr_valid});
        wr(LOG_DEPTH_ADDR, 32'h2);
        wr(CTRL_LO_ADDR, 32'h80);
        ev(8'h01);
        ev(8'h01);
        chk("no_irq", 64'h0, {63'h0, log_full_irq});
        ev(8'h01);
        chk("wrap_index", 64'h0, {56'h0, mem_wr_index});
        tick();
        chk("mem_count", 64'h5, {56'h0, mem_cnt});
        $display("test memory log done");
        wr(CTRL_LO_ADDR, 32'h43);
        @(posedge pclk);
        step_flag <= 1'b1;
        tick();
        p0 = top_ptr;
        ev(8'h08);
        chk("no_step", 64'h0, {63'h0, fault_valid});
        ev(8'h09);
        chk("step_valid", 64'h1, {63'h0, fault_valid});
        chk("step_vector", 64'h1, {56'h0, fault_vector});
        tick();
        chk("fault_once", {62'h0, p0 + 2'h1}, {62'h0, top_ptr});
        chk("rec_top", rec, top_record);
        rd(CTRL_LO_ADDR, 32'h40, "ctrl_after_fault");
        ev(8'h08);
        chk("insn_step", 64'h1, {63'h0, fault_valid});
        tick();
        chk("fault_unlogged", {62'h0, p0 + 2'h1}, {62'h0, top_ptr});
        @(posedge pclk);
        step_flag <= 1'b0;
        $display("test stepping done");
        wr(CNT_EN_ADDR, 32'hff);
        wr(CTRL_LO_ADDR, 32'h1841);
        ev(8'h20);
        tick();
        chk("cnt_frozen", 64'h0, {56'h0, counter_enables});
        p0 = top_ptr;
        ev(8'h01);
        tick();
        chk("stack_frozen", {62'h0, p0}, {62'h0, top_ptr});
        rd(CTRL_LO_ADDR, 32'h1840, "ctrl_frozen");
        $display("test counter irq done");
        wr(CNT_EN_ADDR, 32'hff);
        wr(CTRL_LO_ADDR, 32'h40c3);
        ev(8'h40);
        tick();
        chk("cnt_mgmt", 64'h0, {56'h0, counter_enables});
        rd(CTRL_LO_ADDR, 32'h4000, "ctrl_mgmt");
        ev(8'h80);
        tick();
        chk("cnt_ret", 64'hff, {56'h0, counter_enables});
        rd(CTRL_LO_ADDR, 32'h40c3, "ctrl_ret");
        $display("test management mode done");
        finish_test();
    end
endmodule
